/* File: src/alarm_status_and_mask.v */
// Purpose: Alarm flags, alarm mask and combined alarm summary behind AHB-Lite.
// Assumes: One 250 MHz clock; event inputs come from logic on that clock.
// Notes:   Lane FIFO and PLL alarm sources live elsewhere; their flags only reset and clear here.
//
// Overview of operation
// - The realignment flag is set whenever a system reference pulse realigns the internal clocks and holds until one is written to it.
// - The clock flag is set whenever the first channel pair dividers differ from the second pair and clears on a write of one.
// - After power-on or soft reset every alarm flag starts in the set state.
// - While the serial link is disabled only the clock flag is meaningful; the others may hold any value.
// - The mask resets to 0x3f with bit 5 fifo, 4 pll, 3 link, 2 realign, 0 clock and bits 7:6 and 1 reserved.
// - A mask bit of one keeps its flag out of the summary while the flag still records events.
// - The link flag is set when the link is enabled but not sending data in 8b/10b, or at start-up or realignment in 64b/66b.
`timescale 1ns/100ps
`include "alarm_defines.vh"
module alarm_status_and_mask #(
    parameter DIV_W = 4
) (
    input  wire                 clock_i,
    input  wire                 reset_n_i,
    // AHB-Lite slave
    input  wire                 hsel_i,
    input  wire [31:0]          haddr_i,
    input  wire [1:0]           htrans_i,
    input  wire                 hwrite_i,
    input  wire [2:0]           hsize_i,
    input  wire                 hready_i,
    input  wire [`WORD_W-1:0]   hwdata_i,
    output wire [`WORD_W-1:0]   hrdata_o,
    output wire                 hreadyout_o,
    output wire                 hresp_o,
    // Alarm sources
    input  wire                 realign_pulse_i,
    input  wire [DIV_W-1:0]     div_ab_i,
    input  wire [DIV_W-1:0]     div_cd_i,
    input  wire                 link_data_state_i,
    input  wire                 link_startup_i,
    input  wire                 link_realign_i,
    // Results
    output reg                  serial_link_enable_o,
    output reg                  alarm_o,
    output reg                  irq_o
);

    // Register port wiring
    wire [9:0]          reg_idx;
    wire                reg_hit;
    wire                wr_en;
    wire [`WORD_W-1:0]  wr_data;
    reg  [`WORD_W-1:0]  rd_data;

    // Software state
    reg  [`ALARM_W-1:0] alarm_enable_mask_r;
    reg                 mode_66b_r;
    reg                 soft_reset_r;
    reg  [`ALARM_W-1:0] irq_enable_r;

    // Flag banks
    wire [`ALARM_W-1:0] alarm_flags;
    wire [`ALARM_W-1:0] irq_status;
    reg  [`ALARM_W-1:0] event_set;
    wire [`ALARM_W-1:0] flag_clear;
    wire [`ALARM_W-1:0] irq_clear;

    // Write decode strobes
    wire wr_flags  = wr_en & reg_hit & (reg_idx == `IDX_ALARM_FLAGS);
    wire wr_mask   = wr_en & reg_hit & (reg_idx == `IDX_ALARM_MASK);
    wire wr_ctrl   = wr_en & reg_hit & (reg_idx == `IDX_LINK_CTRL);
    wire wr_irqclr = wr_en & reg_hit & (reg_idx == `IDX_IRQ_CLEAR);
    wire wr_irqen  = wr_en & reg_hit & (reg_idx == `IDX_IRQ_ENABLE);

    // Bus front end; hsize is accepted but only word transfers are meaningful
    ahb_reg_port u_port (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hready_i    (hready_i),
        .hwdata_i    (hwdata_i),
        .rd_data_i   (rd_data),
        .reg_idx_o   (reg_idx),
        .reg_hit_o   (reg_hit),
        .wr_en_o     (wr_en),
        .wr_data_o   (wr_data),
        .hrdata_o    (hrdata_o),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o)
    );

    // Software registers; soft reset restores the mask like a power-on reset
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_enable_mask_r  <= `MASK_RESET;
            serial_link_enable_o <= 1'b0;
            mode_66b_r           <= 1'b0;
            soft_reset_r         <= 1'b0;
            irq_enable_r         <= `IRQ_RESET;
        end else begin
            soft_reset_r <= wr_ctrl & wr_data[`CTRL_SOFT_RESET];
            if (soft_reset_r) begin
                alarm_enable_mask_r <= `MASK_RESET;
            end else if (wr_mask) begin
                // Reserved mask bits are plain storage and read back as written
                alarm_enable_mask_r <= wr_data[`ALARM_W-1:0];
            end
            if (wr_ctrl) begin
                serial_link_enable_o <= wr_data[`CTRL_LINK_EN];
                mode_66b_r           <= wr_data[`CTRL_MODE_66B];
            end
            if (wr_irqen) begin
                irq_enable_r <= wr_data[`ALARM_W-1:0];
            end
        end
    end

    // Alarm events. The realign flag keeps collecting while the link is off;
    // their content is then meaningless and software clears them after enabling.
    always @* begin
        event_set = {`ALARM_W{1'b0}};
        event_set[`BIT_REALIGN] = realign_pulse_i;
        event_set[`BIT_DIVIDER] = (div_ab_i != div_cd_i);
        if (serial_link_enable_o) begin
            if (mode_66b_r) begin
                event_set[`BIT_LINK] = link_startup_i | link_realign_i;
            end else begin
                event_set[`BIT_LINK] = ~link_data_state_i;
            end
        end
    end

    // Write-one-to-clear; the bank lets a same-cycle event win
    assign flag_clear = wr_flags ? wr_data[`ALARM_W-1:0] : {`ALARM_W{1'b0}};
    assign irq_clear  = wr_irqclr ? wr_data[`ALARM_W-1:0] : {`ALARM_W{1'b0}};

    // Alarm flags start set after any reset
    sticky_flag_bank #(
        .WIDTH     (`ALARM_W),
        .IMPL      (`FLAGS_IMPL),
        .RESET_VAL (`FLAGS_RESET)
    ) u_flags (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .init_i    (soft_reset_r),
        .set_i     (event_set),
        .clear_i   (flag_clear),
        .flags_o   (alarm_flags)
    );

    // Interrupt causes record each alarm event regardless of the alarm mask
    sticky_flag_bank #(
        .WIDTH     (`ALARM_W),
        .IMPL      (`FLAGS_IMPL),
        .RESET_VAL (`IRQ_RESET)
    ) u_irq (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .init_i    (soft_reset_r),
        .set_i     (event_set),
        .clear_i   (irq_clear),
        .flags_o   (irq_status)
    );

    // Summary and interrupt, both registered so outputs come from flops
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_o <= 1'b0;
            irq_o   <= 1'b0;
        end else begin
            alarm_o <= |(alarm_flags & ~alarm_enable_mask_r);
            irq_o   <= |(irq_status & irq_enable_r);
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always @* begin
        rd_data = 32'h0000_0000;
        if (reg_hit) begin
            case (reg_idx)
                `IDX_ALARM_FLAGS: rd_data[`ALARM_W-1:0] = alarm_flags;
                `IDX_ALARM_MASK:  rd_data[`ALARM_W-1:0] = alarm_enable_mask_r;
                `IDX_LINK_CTRL: begin
                    rd_data[`CTRL_LINK_EN]  = serial_link_enable_o;
                    rd_data[`CTRL_MODE_66B] = mode_66b_r;
                end
                `IDX_IRQ_STATUS:  rd_data[`ALARM_W-1:0] = irq_status;
                `IDX_IRQ_ENABLE:  rd_data[`ALARM_W-1:0] = irq_enable_r;
                default:          rd_data = 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: src/alarm_defines.vh */
// Purpose: Shared constants for the alarm status and mask block.
// Assumes: Registers are word aligned; byte address is four times the index.
// Notes:   Definitions only, no logic.
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

// Register indices (byte address = index * 4)
`define IDX_ALARM_FLAGS     10'h2c0
`define IDX_ALARM_MASK      10'h2c2
`define IDX_LINK_CTRL       10'h2c6
`define IDX_IRQ_STATUS      10'h2c8
`define IDX_IRQ_CLEAR       10'h2c9
`define IDX_IRQ_ENABLE      10'h2ca

// Address split: word index field and upper bits that must be zero
`define ADDR_IDX_MSB        11
`define ADDR_IDX_LSB        2
`define ADDR_HIT_LSB        12
`define ADDR_HIT_ZERO       20'h00000

// Alarm flag and mask bit positions
`define BIT_DIVIDER         0
`define BIT_REALIGN         2
`define BIT_LINK            3
`define BIT_PLL             4
`define BIT_FIFO            5

// Flag and mask widths and reset values
`define ALARM_W             8
`define FLAGS_IMPL          8'h3d
`define FLAGS_RESET         8'h3d
`define MASK_RESET          8'h3f
`define IRQ_RESET           8'h00

// Link control register bits
`define CTRL_LINK_EN        0
`define CTRL_MODE_66B       1
`define CTRL_SOFT_RESET     2
`define CTRL_RESET          8'h00

// AHB-Lite encodings
`define HTRANS_ACTIVE_BIT   1
`define HRESP_OKAY          1'b0
`define WORD_W              32

`endif

/* File: src/sticky_flag_bank.v */
// Purpose: Bank of sticky flags, one flip-flop per implemented bit.
// Assumes: Single clock; set, clear and init come from logic on that clock.
// Notes:   Init beats set, set beats clear; unimplemented bits read zero.
`timescale 1ns/100ps
module sticky_flag_bank #(
    parameter WIDTH     = 8,
    parameter [WIDTH-1:0] IMPL      = 8'hff,
    parameter [WIDTH-1:0] RESET_VAL = 8'h00
) (
    input  wire             clock_i,
    input  wire             reset_n_i,
    input  wire             init_i,
    input  wire [WIDTH-1:0] set_i,
    input  wire [WIDTH-1:0] clear_i,
    output wire [WIDTH-1:0] flags_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
            if (IMPL[g]) begin : gen_flop
                reg flag_r;
                // Set wins over a clear in the same cycle so no event is lost
                always @(posedge clock_i or negedge reset_n_i) begin
                    if (!reset_n_i) begin
                        flag_r <= RESET_VAL[g];
                    end else if (init_i) begin
                        flag_r <= RESET_VAL[g];
                    end else if (set_i[g]) begin
                        flag_r <= 1'b1;
                    end else if (clear_i[g]) begin
                        flag_r <= 1'b0;
                    end
                end
                assign flags_o[g] = flag_r;
            end else begin : gen_none
                assign flags_o[g] = 1'b0;
            end
        end
    endgenerate

endmodule

/* File: src/ahb_reg_port.v */
// Purpose: AHB-Lite slave front end turning bus transfers into register strobes.
// Assumes: Single word transfers; one wait state on every transfer.
// Notes:   Response is always OKAY; unmapped decoding is left to the register file.
`timescale 1ns/100ps
`include "alarm_defines.vh"
module ahb_reg_port (
    input  wire                 clock_i,
    input  wire                 reset_n_i,
    input  wire                 hsel_i,
    input  wire [31:0]          haddr_i,
    input  wire [1:0]           htrans_i,
    input  wire                 hwrite_i,
    input  wire                 hready_i,
    input  wire [`WORD_W-1:0]   hwdata_i,
    input  wire [`WORD_W-1:0]   rd_data_i,
    output reg  [9:0]           reg_idx_o,
    output reg                  reg_hit_o,
    output reg                  wr_en_o,
    output reg  [`WORD_W-1:0]   wr_data_o,
    output reg  [`WORD_W-1:0]   hrdata_o,
    output reg                  hreadyout_o,
    output reg                  hresp_o
);

    reg pending_r;
    reg write_r;

    wire take = hsel_i & htrans_i[`HTRANS_ACTIVE_BIT] & hready_i;

    // Address phase capture, then a single wait cycle in the data phase.
    // The wait lets read data come from a flop instead of a decode path.
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_r   <= 1'b0;
            write_r     <= 1'b0;
            reg_idx_o   <= 10'h000;
            reg_hit_o   <= 1'b0;
            wr_en_o     <= 1'b0;
            wr_data_o   <= 32'h0000_0000;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= `HRESP_OKAY;
        end else begin
            wr_en_o <= 1'b0;
            hresp_o <= `HRESP_OKAY;
            if (take) begin
                pending_r   <= 1'b1;
                write_r     <= hwrite_i;
                reg_idx_o   <= haddr_i[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
                // Upper bits are decoded so a far address cannot alias onto a register
                reg_hit_o   <= (haddr_i[31:`ADDR_HIT_LSB] == `ADDR_HIT_ZERO);
                hreadyout_o <= 1'b0;
            end else if (pending_r) begin
                pending_r   <= 1'b0;
                hreadyout_o <= 1'b1;
                if (write_r) begin
                    wr_en_o   <= 1'b1;
                    wr_data_o <= hwdata_i;
                end else begin
                    hrdata_o <= rd_data_i;
                end
            end
        end
    end

endmodule

/* File: tb/alarm_chk_assertions.sv */
// Purpose: Bus, flag and summary properties for the alarm block.
// Assumes: Mask and mode are shadowed one edge after the data phase, an edge after the registers land.
// Notes:   Flags are hidden, so alarm_o is the window onto them.
`timescale 1ns/100ps
`include "alarm_defines.vh"
module alarm_chk #(
    parameter DIV_W = 4
) (
    input wire               clock_i,
    input wire               reset_n_i,
    input wire               hsel_i,
    input wire [31:0]        haddr_i,
    input wire [1:0]         htrans_i,
    input wire               hwrite_i,
    input wire               hready_i,
    input wire [`WORD_W-1:0] hwdata_i,
    input wire [`WORD_W-1:0] hrdata_o,
    input wire               hreadyout_o,
    input wire               hresp_o,
    input wire               realign_pulse_i,
    input wire [DIV_W-1:0]   div_ab_i,
    input wire [DIV_W-1:0]   div_cd_i,
    input wire               link_data_state_i,
    input wire               link_startup_i,
    input wire               link_realign_i,
    input wire               serial_link_enable_o,
    input wire               alarm_o
);
    reg        ph_r;
    reg        ap_r;
    reg        mode_r;
    reg [11:0] adr_r;
    reg [7:0]  dat_r;
    reg [7:0]  msk_r;
    wire       tk   = hsel_i & htrans_i[1] & hready_i;
    wire       idle = !ph_r && !ap_r;

    // Shadow writes; idle keeps properties away from half-landed writes
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ph_r   <= 1'b0;
            ap_r   <= 1'b0;
            mode_r <= 1'b0;
            adr_r  <= 12'h000;
            dat_r  <= 8'h00;
            msk_r  <= 8'h3f;
        end else begin
            ap_r <= ph_r && hreadyout_o;
            if (ph_r && hreadyout_o) begin
                ph_r  <= 1'b0;
                dat_r <= hwdata_i[7:0];
            end
            if (tk) begin
                ph_r  <= hwrite_i && haddr_i[31:12] == 20'h00000;
                adr_r <= haddr_i[11:0];
            end
            if (ap_r && adr_r == 12'hb08)
                msk_r <= dat_r;
            if (ap_r && adr_r == 12'hb18) begin
                mode_r <= dat_r[1];
                if (dat_r[2])
                    msk_r <= 8'h3f;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_one_wait: assert property (tk |=> !hreadyout_o ##1 hreadyout_o) else $error("wait state wrong");
    a_resp_okay: assert property (!hresp_o) else $error("response not okay");
    a_rdata_hold: assert property (hreadyout_o && !tk |=> $stable(hrdata_o)) else $error("read data moved");
    a_realign_alarm: assert property (idle && realign_pulse_i && !msk_r[2] |-> ##2 alarm_o)
        else $error("realign pulse lost");
    a_divider_alarm: assert property (idle && div_ab_i != div_cd_i && !msk_r[0] |-> ##2 alarm_o)
        else $error("divider mismatch lost");
    a_link_8b_alarm: assert property (idle && serial_link_enable_o && !mode_r && !link_data_state_i
        && !msk_r[3] |-> ##2 alarm_o) else $error("link state alarm lost");
    a_link_66b_alarm: assert property (idle && serial_link_enable_o && mode_r
        && (link_startup_i || link_realign_i) && !msk_r[3] |-> ##2 alarm_o) else $error("link start alarm lost");
    a_masked_quiet: assert property (((msk_r & 8'h3d) == 8'h3d)[*3] |-> !alarm_o)
        else $error("masked summary high");

    c_read: cover property (tk && !hwrite_i);
    c_realign: cover property (realign_pulse_i && !msk_r[2]);
    c_start_66b: cover property (serial_link_enable_o && mode_r && link_startup_i);
endmodule

bind alarm_status_and_mask alarm_chk #(.DIV_W(DIV_W)) u_alarm_chk (.clock_i, .reset_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .realign_pulse_i, .div_ab_i,
    .div_cd_i, .link_data_state_i, .link_startup_i, .link_realign_i, .serial_link_enable_o, .alarm_o);

/* File: tb/alarm_status_and_mask_test.sv */
// Purpose: Directed register and event scenarios for the alarm block.
// Assumes: Single word AHB-Lite transfers; hready fed back from hreadyout.
// Notes:   Byte address is four times the register index.
`timescale 1ns/100ps
module alarm_status_and_mask_test;
    reg        clk    = 1'b0;
    reg        rst_n  = 1'b0;
    reg        sel    = 1'b0;
    reg [31:0] addr   = 32'h0;
    reg [1:0]  trans  = 2'b00;
    reg        wr     = 1'b0;
    reg [31:0] wdata  = 32'h0;
    reg        pulse  = 1'b0;
    reg [3:0]  dab    = 4'h0;
    reg [3:0]  dcd    = 4'h0;
    reg        dstate = 1'b0;
    reg        lstart = 1'b0;
    reg        lreal  = 1'b0;
    wire [31:0] rdata;
    wire       rdy, resp, len, alm, irq;
    int        error_cnt  = 0;
    int        n_compared = 0;
    int        cyc        = 0;

    always #2 clk = ~clk;

    alarm_status_and_mask u_alarm_status_and_mask (.clock_i(clk), .reset_n_i(rst_n), .hsel_i(sel),
        .haddr_i(addr), .htrans_i(trans), .hwrite_i(wr), .hsize_i(3'h2), .hready_i(rdy), .hwdata_i(wdata),
        .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(resp), .realign_pulse_i(pulse), .div_ab_i(dab),
        .div_cd_i(dcd), .link_data_state_i(dstate), .link_startup_i(lstart), .link_realign_i(lreal),
        .serial_link_enable_o(len), .alarm_o(alm), .irq_o(irq));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One transfer; the wait is open ended, the cycle ceiling ends a hang
    task automatic xfer(input reg w, input reg [31:0] a, input reg [7:0] d, output reg [31:0] q);
        sel   <= 1'b1;
        trans <= 2'b10;
        wr    <= w;
        addr  <= a;
        do @(posedge clk); while (rdy !== 1'b1);
        sel   <= 1'b0;
        trans <= 2'b00;
        wdata <= {24'h0, d};
        do @(posedge clk); while (rdy !== 1'b1);
        #1 q = rdata;
    endtask

    task automatic chk_word(input reg [31:0] g, input reg [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t read %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input reg g, input reg e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t output %b expected %b", $time, g, e);
        end
    endtask

    task automatic wreg(input reg [11:0] a, input reg [7:0] d);
        reg [31:0] q;
        xfer(1'b1, {20'h0, a}, d, q);
    endtask

    task automatic rchk(input reg [11:0] a, input reg [31:0] e);
        reg [31:0] q;
        xfer(1'b0, {20'h0, a}, 8'h00, q);
        chk_word(q, e);
    endtask

    task automatic sysref;
        pulse <= 1'b1;
        tick(1);
        pulse <= 1'b0;
        tick(3);
    endtask

    // Far addresses must neither write the mask nor read the flags
    task automatic t_reset;
        reg [31:0] q;
        rchk(12'hb00, 32'h3d);
        xfer(1'b1, 32'h0000_1b08, 8'h00, q);
        xfer(1'b0, 32'h0000_1b00, 8'h00, q);
        chk_word(q, 32'h0);
        rchk(12'hb08, 32'h3f);
        wreg(12'hb04, 8'h5a);
        rchk(12'hb04, 32'h0);
        chk_bit(alm, 1'b0);
    endtask

    task automatic t_realign;
        wreg(12'hb00, 8'hff);
        rchk(12'hb00, 32'h0);
        wreg(12'hb08, 8'h3b);
        sysref;
        chk_bit(alm, 1'b1);
        rchk(12'hb00, 32'h04);
        wreg(12'hb08, 8'h3f);
        tick(2);
        chk_bit(alm, 1'b0);
        rchk(12'hb00, 32'h04);
        wreg(12'hb00, 8'h04);
        rchk(12'hb00, 32'h0);
    endtask

    // Mismatch in the top divider bit only, with the link still off
    task automatic t_divider;
        wreg(12'hb08, 8'h3e);
        dab <= 4'h8;
        tick(2);
        wreg(12'hb00, 8'h01);
        rchk(12'hb00, 32'h01);
        chk_bit(alm, 1'b1);
        dab <= 4'h0;
        tick(1);
        wreg(12'hb00, 8'h01);
        rchk(12'hb00, 32'h0);
        tick(2);
        chk_bit(alm, 1'b0);
    endtask

    task automatic t_link;
        int i;
        wreg(12'hb08, 8'h37);
        wreg(12'hb18, 8'h01);
        tick(2);
        chk_bit(len, 1'b1);
        rchk(12'hb00, 32'h08);
        dstate <= 1'b1;
        wreg(12'hb00, 8'hff);
        rchk(12'hb00, 32'h0);
        wreg(12'hb18, 8'h03);
        dstate <= 1'b0;
        tick(2);
        rchk(12'hb00, 32'h0);
        for (i = 0; i < 2; i++) begin
            {lstart, lreal} <= 2'b10 >> i;
            tick(1);
            {lstart, lreal} <= 2'b00;
            tick(2);
            chk_bit(alm, 1'b1);
            rchk(12'hb00, 32'h08);
            wreg(12'hb00, 8'h08);
        end
        wreg(12'hb18, 8'h00);
    endtask

    task automatic t_soft;
        wreg(12'hb08, 8'hc2);
        rchk(12'hb08, 32'hc2);
        wreg(12'hb18, 8'h04);
        tick(1);
        rchk(12'hb00, 32'h3d);
        rchk(12'hb08, 32'h3f);
        rchk(12'hb18, 32'h0);
        chk_bit(alm, 1'b0);
    endtask

    // Raise, clear and then mask the realign interrupt
    task automatic t_irq;
        wreg(12'hb28, 8'h04);
        sysref;
        chk_bit(irq, 1'b1);
        rchk(12'hb20, 32'h04);
        wreg(12'hb24, 8'h04);
        tick(2);
        chk_bit(irq, 1'b0);
        rchk(12'hb24, 32'h0);
        wreg(12'hb28, 8'h00);
        sysref;
        chk_bit(irq, 1'b0);
        wreg(12'hb20, 8'h00);
        rchk(12'hb20, 32'h04);
        rchk(12'hb28, 32'h0);
    endtask

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Run takes under two hundred cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            close_out;
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        t_reset;
        t_realign;
        t_divider;
        t_link;
        t_soft;
        t_irq;
        close_out;
    end
endmodule
